/* File: core/stats_pkg.sv */
/*
 * Shared constants and types of the MAC statistics counter control block.
 * Assumes register indices are word indices: byte address equals index times four.
 */
package stats_pkg;

    // ************************************************************
    // Sizes and register map.
    // ************************************************************
    localparam int          NCNT            = 12;
    localparam int          CNT_W           = 64;
    localparam int          SEL_W           = 4;
    localparam logic [11:0] TX_CNT_BASE     = 12'h800;
    localparam logic [11:0] RX_CNT_BASE     = 12'h900;
    localparam logic [11:0] TX_CFG_IDX      = 12'h845;
    localparam logic [11:0] TX_STS_IDX      = 12'h846;
    localparam logic [11:0] RX_CFG_IDX      = 12'h945;
    localparam logic [11:0] RX_STS_IDX      = 12'h946;
    localparam int          CFG_CLEAR_BIT   = 0;
    localparam int          CFG_SHADOW_BIT  = 2;
    localparam int          STS_GRANT_BIT   = 1;
    localparam logic        CFG_SHADOW_RST  = 1'b0;

    // ************************************************************
    // Frame size classes, in bytes of DA, SA, data and CRC.
    // ************************************************************
    localparam logic [16:0] CRC_BYTES       = 17'h00004;
    localparam logic [16:0] LEN_MIN         = 17'h00040;
    localparam logic [16:0] LEN_127         = 17'h0007f;
    localparam logic [16:0] LEN_255         = 17'h000ff;
    localparam logic [16:0] LEN_511         = 17'h001ff;
    localparam logic [16:0] LEN_1023        = 17'h003ff;
    localparam logic [16:0] LEN_1518        = 17'h005ee;
    localparam logic [16:0] LEN_MAX         = 17'h02580;

    // Counter slots inside one direction's bank.
    localparam int C_FRAG  = 0;
    localparam int C_JAB   = 1;
    localparam int C_CRC   = 2;
    localparam int C_64    = 3;
    localparam int C_127   = 4;
    localparam int C_255   = 5;
    localparam int C_511   = 6;
    localparam int C_1023  = 7;
    localparam int C_1518  = 8;
    localparam int C_MAXB  = 9;
    localparam int C_OVER  = 10;
    localparam int C_OK    = 11;

    typedef enum logic [1:0] {
        SH_LIVE = 2'b01,
        SH_HELD = 2'b10
    } shadow_state_t;

    typedef logic [NCNT-1:0] inc_vec_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        done;
        logic [15:0] body_len;
        logic        crc_err;
    } frame_evt_t;

endpackage

/* File: core/frame_size_classifier.sv */
/*
 * Turns one frame-end event into a vector of counter increments.
 * Assumes body_len counts DA, SA and data bytes, without preamble, SFD or CRC.
 */
`timescale 1ns/1ps
`default_nettype none
module frame_size_classifier
    import stats_pkg::*;
(
    input  wire frame_evt_t evt,     // Frame-end event.
    input  wire logic       inject,  // Client forced the CRC fault.
    output inc_vec_t        inc      // One bit per counter to bump.
);
    logic [16:0] total;
    logic        err;

    // Size adds the CRC bytes; injected faults are not errors here.
    always_comb begin
        total = {1'b0, evt.body_len} + CRC_BYTES;
        err   = evt.crc_err & ~inject;
        inc   = '0;
        if (evt.done) begin
            if (total < LEN_MIN) begin
                inc[C_FRAG] = err;
            end else begin
                inc[C_CRC] = err;
            end
            if (total == LEN_MIN) begin
                inc[C_64] = 1'b1;
            end else if (total > LEN_MIN && total <= LEN_127) begin
                inc[C_127] = 1'b1;
            end else if (total > LEN_127 && total <= LEN_255) begin
                inc[C_255] = 1'b1;
            end else if (total > LEN_255 && total <= LEN_511) begin
                inc[C_511] = 1'b1;
            end else if (total > LEN_511 && total <= LEN_1023) begin
                inc[C_1023] = 1'b1;
            end else if (total > LEN_1023 && total <= LEN_1518) begin
                inc[C_1518] = 1'b1;
            end else if (total > LEN_1518 && total <= LEN_MAX) begin
                inc[C_MAXB] = 1'b1;
            end else if (total > LEN_MAX) begin
                inc[C_OVER] = 1'b1;
                inc[C_JAB]  = err;
            end
            inc[C_OK] = ~err;
        end
    end
endmodule
`default_nettype wire

/* File: core/stats_counter_bank.sv */
/*
 * One direction's bank of rolling 64-bit counters with a shadow snapshot.
 * Assumes increments, clear and shadow request come from flops of the top.
 */
`timescale 1ns/1ps
`default_nettype none
module stats_counter_bank
    import stats_pkg::*;
(
    input  wire logic             pclk,       // Register clock.
    input  wire logic             presetn,    // Asynchronous reset, low.
    input  wire inc_vec_t         inc,        // Increment pulses.
    input  wire logic             clear,      // Zero every counter.
    input  wire logic             shadow_req, // Hold the snapshot.
    input  wire logic [SEL_W-1:0] rd_sel,     // Counter to read.
    input  wire logic             rd_hi,      // Upper word when high.
    output logic [31:0]           rd_data,    // Readable word.
    output logic                  granted     // Snapshot is held.
);
    typedef struct packed {
        logic [NCNT-1:0][CNT_W-1:0] live;
        logic [NCNT-1:0][CNT_W-1:0] snap;
        shadow_state_t              state;
    } bank_state_t;

    bank_state_t q;
    bank_state_t d;
    logic [CNT_W-1:0] pick;

    // Counters roll over; the snapshot is taken whole in one edge.
    always_comb begin
        d = q;
        for (int i = 0; i < NCNT; i++) begin
            d.live[i] = q.live[i] + {{(CNT_W-1){1'b0}}, inc[i]};
        end
        unique case (q.state)
            SH_LIVE: begin
                if (shadow_req) begin
                    d.snap  = q.live;
                    d.state = SH_HELD;
                end
            end
            SH_HELD: begin
                if (!shadow_req) begin
                    d.state = SH_LIVE;
                end
            end
        endcase
        if (clear) begin
            d.live = '0;
            d.snap = '0;
        end
    end

    // Every counter starts from zero out of reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{live: '0, snap: '0, state: SH_LIVE};
        end else begin
            q <= d;
        end
    end

    // Reads only select; they never touch the counters.
    always_comb begin
        pick    = (q.state == SH_HELD) ? q.snap[rd_sel] : q.live[rd_sel];
        rd_data = rd_hi ? pick[63:32] : pick[31:0];
        granted = (q.state == SH_HELD);
    end
endmodule
`default_nettype wire

/* File: core/mac_stats_counter_control.sv */
/*
 * Top of the MAC statistics counter control: APB register slave, clear and
 * shadow control, increment vector export and the two counter banks.
 * Assumes an APB master on pclk and frame events synchronous to pclk.
 */
// Contract
// - Every statistics counter is 64 bits and rolls over to zero.
// - Frame size counts DA, SA, data and four CRC bytes only.
// - Counter bank exists only when the build option enables it.
// - Reset low clears every statistics counter to zero.
// - Clear command in the transmit config register zeroes all transmit counters.
// - Clear command in the receive config register zeroes all receive counters.
// - Per-event increment vectors pulse once for each counted event.
// - Reading a counter word leaves its value unchanged.
// - Held shadow bit freezes readable values while live counters keep counting.
// - Status register bit reports whether the shadow request is granted.
// - Lower counter half at the even address, upper half at the next.
// - Transmit counters ignore CRC faults the client injects on purpose.
`timescale 1ns/1ps
`default_nettype none
module mac_stats_counter_control
    import stats_pkg::*;
#(
    parameter bit STATS_ENABLE = 1'b1
)
(
    input  wire logic       pclk,                       // Register clock.
    input  wire logic       presetn,                    // Asynchronous reset, low.
    input  wire apb_req_t   apb_req,                    // APB request group.
    output logic [31:0]     prdata,                     // APB read data.
    output logic            pready,                     // APB ready.
    output logic            pslverr,                    // APB error answer.
    input  wire frame_evt_t tx_evt,                     // Transmit frame end.
    input  wire logic       client_tx_inject_crc_fault, // Forced CRC fault.
    input  wire frame_evt_t rx_evt,                     // Receive frame end.
    output inc_vec_t        tx_inc_vec,                 // Transmit increments.
    output inc_vec_t        rx_inc_vec,                 // Receive increments.
    output logic            tx_shadow_granted,          // Transmit snapshot held.
    output logic            rx_shadow_granted           // Receive snapshot held.
);

    // ************************************************************
    // State of the register side.
    // ************************************************************
    typedef struct packed {
        logic        tx_shadow;
        logic        rx_shadow;
        logic        tx_clear;
        logic        rx_clear;
        logic [31:0] rdata;
        logic        slverr;
        inc_vec_t    tx_inc;
        inc_vec_t    rx_inc;
    } top_state_t;

    top_state_t q;
    top_state_t d;

    logic [11:0]      idx;
    logic             setup;
    logic             wr_access;
    inc_vec_t         tx_cls;
    inc_vec_t         rx_cls;
    logic [31:0]      tx_rd;
    logic [31:0]      rx_rd;
    logic             tx_grant;
    logic             rx_grant;
    logic [SEL_W-1:0] tx_sel;
    logic [SEL_W-1:0] rx_sel;
    logic             tx_hit;
    logic             rx_hit;

    // ************************************************************
    // Address decode helpers.
    // ************************************************************

    // True when the word index falls on a counter of the bank at base.
    function automatic logic cnt_hit(
        input logic [11:0] i,
        input logic [11:0] base
    );
        logic [11:0] off;
        off     = i - base;
        cnt_hit = (i >= base) && (off < 12'(2 * NCNT));
    endfunction

    // Counter slot addressed by the word index; bit 0 picks the half.
    function automatic logic [SEL_W-1:0] cnt_sel(
        input logic [11:0] i,
        input logic [11:0] base
    );
        logic [11:0] off;
        off     = i - base;
        cnt_sel = off[SEL_W:1];
    endfunction

    // Read-back image of a configuration register.
    function automatic logic [31:0] cfg_word(input logic shadow);
        logic [31:0] w;
        w                 = '0;
        w[CFG_SHADOW_BIT] = shadow;
        cfg_word          = w;
    endfunction

    // Read-back image of a status register.
    function automatic logic [31:0] sts_word(input logic grant);
        logic [31:0] w;
        w                = '0;
        w[STS_GRANT_BIT] = grant;
        sts_word         = w;
    endfunction

    // ************************************************************
    // Frame classification and increment export.
    // ************************************************************

    // The transmit side sees the client's forced fault, the receive side never does.
    frame_size_classifier u_tx_cls (
        .evt    (tx_evt),
        .inject (client_tx_inject_crc_fault),
        .inc    (tx_cls)
    );

    frame_size_classifier u_rx_cls (
        .evt    (rx_evt),
        .inject (1'b0),
        .inc    (rx_cls)
    );

    // ************************************************************
    // Counter banks, present only when the option builds them.
    // ************************************************************
    generate
        if (STATS_ENABLE) begin : g_banks
            stats_counter_bank u_tx_bank (
                .pclk       (pclk),
                .presetn    (presetn),
                .inc        (q.tx_inc),
                .clear      (q.tx_clear),
                .shadow_req (q.tx_shadow),
                .rd_sel     (tx_sel),
                .rd_hi      (idx[0]),
                .rd_data    (tx_rd),
                .granted    (tx_grant)
            );

            stats_counter_bank u_rx_bank (
                .pclk       (pclk),
                .presetn    (presetn),
                .inc        (q.rx_inc),
                .clear      (q.rx_clear),
                .shadow_req (q.rx_shadow),
                .rd_sel     (rx_sel),
                .rd_hi      (idx[0]),
                .rd_data    (rx_rd),
                .granted    (rx_grant)
            );
        end else begin : g_no_banks
            // Without the bank, counter reads answer zero and nothing is granted.
            assign tx_rd    = '0;
            assign rx_rd    = '0;
            assign tx_grant = 1'b0;
            assign rx_grant = 1'b0;
        end
    endgenerate

    // ************************************************************
    // Bus decode.
    // ************************************************************

    // The base addresses are even, so bit 0 of the index selects the half.
    always_comb begin
        idx       = apb_req.paddr[13:2];
        setup     = apb_req.psel & ~apb_req.penable;
        wr_access = apb_req.psel & apb_req.penable & apb_req.pwrite;
        tx_hit    = cnt_hit(idx, TX_CNT_BASE);
        rx_hit    = cnt_hit(idx, RX_CNT_BASE);
        tx_sel    = tx_hit ? cnt_sel(idx, TX_CNT_BASE) : '0;
        rx_sel    = rx_hit ? cnt_sel(idx, RX_CNT_BASE) : '0;
    end

    // ************************************************************
    // Next state.
    // ************************************************************

    // Clear commands are one-cycle pulses; the shadow bits hold until rewritten.
    always_comb begin
        d          = q;
        d.tx_clear = 1'b0;
        d.rx_clear = 1'b0;
        d.tx_inc   = tx_cls;
        d.rx_inc   = rx_cls;
        if (wr_access) begin
            if (idx == TX_CFG_IDX) begin
                d.tx_shadow = apb_req.pwdata[CFG_SHADOW_BIT];
                d.tx_clear  = apb_req.pwdata[CFG_CLEAR_BIT];
            end
            if (idx == RX_CFG_IDX) begin
                d.rx_shadow = apb_req.pwdata[CFG_SHADOW_BIT];
                d.rx_clear  = apb_req.pwdata[CFG_CLEAR_BIT];
            end
        end
        // Read data and the error answer are latched in the setup cycle,
        // so the access cycle can finish at once with data from flops.
        if (setup) begin
            d.rdata  = '0;
            d.slverr = 1'b0;
            if (tx_hit) begin
                d.rdata = apb_req.pwrite ? 32'h0000_0000 : tx_rd;
            end else if (rx_hit) begin
                d.rdata = apb_req.pwrite ? 32'h0000_0000 : rx_rd;
            end else if (idx == TX_CFG_IDX) begin
                d.rdata = cfg_word(q.tx_shadow);
            end else if (idx == RX_CFG_IDX) begin
                d.rdata = cfg_word(q.rx_shadow);
            end else if (idx == TX_STS_IDX) begin
                d.rdata = sts_word(tx_grant);
            end else if (idx == RX_STS_IDX) begin
                d.rdata = sts_word(rx_grant);
            end else begin
                d.slverr = 1'b1;
            end
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{tx_shadow: CFG_SHADOW_RST,
                   rx_shadow: CFG_SHADOW_RST,
                   tx_clear:  1'b0,
                   rx_clear:  1'b0,
                   rdata:     32'h0000_0000,
                   slverr:    1'b0,
                   tx_inc:    '0,
                   rx_inc:    '0};
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************

    // No wait states: every access phase ends at its first edge.
    // The error answer is gated so it only shows in an access phase.
    always_comb begin
        pready            = 1'b1;
        prdata            = q.rdata;
        pslverr           = q.slverr & apb_req.psel & apb_req.penable;
        tx_inc_vec        = q.tx_inc;
        rx_inc_vec        = q.rx_inc;
        tx_shadow_granted = tx_grant;
        rx_shadow_granted = rx_grant;
    end

endmodule
`default_nettype wire

/* File: tb/mac_stats_monitor.sv */
/*
 * Port checker for the statistics counter control block.
 * Assumes one pclk domain and attachment through the bind at the foot.
 */
`timescale 1ns/1ps
`default_nettype none
module mac_stats_monitor
    import stats_pkg::*;
#(
    parameter bit STATS_ENABLE = 1'b1
)
(
    input wire logic        pclk,                       // Register clock.
    input wire logic        presetn,                    // Reset, low.
    input wire apb_req_t    apb_req,                    // APB request.
    input wire logic [31:0] prdata,                     // Read data.
    input wire logic        pready,                     // Ready.
    input wire logic        pslverr,                    // Error answer.
    input wire frame_evt_t  tx_evt,                     // Transmit event.
    input wire logic        client_tx_inject_crc_fault, // Forced fault.
    input wire frame_evt_t  rx_evt,                     // Receive event.
    input wire inc_vec_t    tx_inc_vec,                 // Transmit bumps.
    input wire inc_vec_t    rx_inc_vec,                 // Receive bumps.
    input wire logic        tx_shadow_granted,          // Transmit grant.
    input wire logic        rx_shadow_granted           // Receive grant.
);
    // ************************************************************
    // Decoded register accesses.
    // ************************************************************
    logic acc;
    logic wr_txc;
    logic wr_rxc;
    logic rd_txs;

    // Decodes are plain compares so the assertions stay short.
    assign acc    = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign wr_txc = acc && apb_req.paddr == {2'b00, TX_CFG_IDX, 2'b00};
    assign wr_rxc = acc && apb_req.paddr == {2'b00, RX_CFG_IDX, 2'b00};
    assign rd_txs = apb_req.psel && !apb_req.penable && !apb_req.pwrite
                    && apb_req.paddr == {2'b00, TX_STS_IDX, 2'b00};

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tx_good_size: assert property (
        tx_evt.done && tx_evt.body_len == 16'h003c && !tx_evt.crc_err
        |=> tx_inc_vec == 12'h808) else $error("tx 64 byte increments wrong");
    a_tx_inject_hidden: assert property (
        tx_evt.done && tx_evt.crc_err && client_tx_inject_crc_fault && tx_evt.body_len == 16'h003c
        |=> tx_inc_vec == 12'h808) else $error("injected fault was counted");
    a_rx_crc_count: assert property (
        rx_evt.done && rx_evt.crc_err && rx_evt.body_len == 16'h003c
        |=> rx_inc_vec == 12'h00c) else $error("rx crc increments wrong");
    a_tx_idle_quiet: assert property (!tx_evt.done |=> tx_inc_vec == '0)
        else $error("tx increment without event");
    a_rx_idle_quiet: assert property (!rx_evt.done |=> rx_inc_vec == '0)
        else $error("rx increment without event");
    a_tx_grant_rise: assert property (
        wr_txc && apb_req.pwdata[2] && !tx_shadow_granted
        |=> !tx_shadow_granted ##1 tx_shadow_granted) else $error("tx grant timing");
    a_rx_grant_rise: assert property (
        wr_rxc && apb_req.pwdata[2] && !rx_shadow_granted
        |=> !rx_shadow_granted ##1 rx_shadow_granted) else $error("rx grant timing");
    a_tx_grant_fall: assert property (
        wr_txc && !apb_req.pwdata[2] && tx_shadow_granted
        |=> ##1 !tx_shadow_granted) else $error("tx grant not released");
    a_tx_grant_hold: assert property (
        tx_shadow_granted && !wr_txc && !$past(wr_txc) |=> tx_shadow_granted)
        else $error("tx grant dropped alone");
    a_status_grant: assert property (
        rd_txs |=> prdata[1] == $past(tx_shadow_granted)) else $error("status bit wrong");
    a_reset_quiet: assert property (disable iff (1'b0)
        !presetn |-> tx_inc_vec == '0 && rx_inc_vec == '0 && !tx_shadow_granted)
        else $error("outputs active in reset");

    // Main scenarios seen at least once.
    c_grant: cover property (wr_txc && apb_req.pwdata[2]);
    c_inject: cover property (tx_evt.done && client_tx_inject_crc_fault);
    c_rx_err: cover property (rx_evt.done && rx_evt.crc_err);
endmodule

bind mac_stats_counter_control mac_stats_monitor #(.STATS_ENABLE(STATS_ENABLE)) u_mon (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_evt(tx_evt), .rx_evt(rx_evt), .tx_inc_vec(tx_inc_vec),
    .client_tx_inject_crc_fault(client_tx_inject_crc_fault), .rx_inc_vec(rx_inc_vec),
    .tx_shadow_granted(tx_shadow_granted), .rx_shadow_granted(rx_shadow_granted));
`default_nettype wire

/* File: tb/test_mac_stats_counter_control.sv */
/*
 * Self-checking bench for the statistics counter control block.
 * Assumes the package constants and the APB timing of the block.
 */
`timescale 1ns/1ps
`default_nettype none
module test_mac_stats_counter_control
    import stats_pkg::*;
;
    // ************************************************************
    // Signals and expectation model.
    // ************************************************************
    localparam logic [16:0] UB [8] = '{LEN_MIN, LEN_127, LEN_255, LEN_511,
                                       LEN_1023, LEN_1518, LEN_MAX, 17'h1ffff};
    logic        pclk;
    logic        presetn;
    apb_req_t    apb_req;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    frame_evt_t  tx_evt;
    frame_evt_t  rx_evt;
    logic        client_tx_inject_crc_fault;
    inc_vec_t    tx_inc_vec;
    inc_vec_t    rx_inc_vec;
    logic        tx_shadow_granted;
    logic        rx_shadow_granted;
    logic [63:0] exp_cnt [2][NCNT];
    logic [63:0] snap [2][NCNT];
    bit          held [2];
    int          miscompares;
    int          comparisons;

    mac_stats_counter_control DUT (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_evt(tx_evt), .rx_evt(rx_evt),
        .client_tx_inject_crc_fault(client_tx_inject_crc_fault),
        .tx_inc_vec(tx_inc_vec), .rx_inc_vec(rx_inc_vec),
        .tx_shadow_granted(tx_shadow_granted), .rx_shadow_granted(rx_shadow_granted));

    // Free-running register clock.
    always #25 pclk = ~pclk;

    task automatic test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // One transfer; two idle edges after it let clear and grant settle.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        apb_req <= '{1'b1, 1'b0, w, {2'b00, a, 2'b00}, wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic rdc(input string n, input logic [11:0] a, input logic [63:0] e);
        logic [31:0] d;
        logic        r;
        apb(1'b0, a, '0, d, r);
        chk(n, e, d);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        r;
        apb(1'b1, a, wd, d, r);
    endtask

    function automatic inc_vec_t cls(input logic [16:0] len, input bit err);
        inc_vec_t    m;
        logic [16:0] lo;
        m = '0;
        lo = LEN_MIN;
        for (int k = 0; k < 8; k++) begin
            m[3 + k] = len >= lo && len <= UB[k];
            lo = UB[k] + 17'h00001;
        end
        m[0] = err && len < LEN_MIN;
        m[1] = err && len > LEN_MAX;
        m[2] = err && len >= LEN_MIN;
        m[11] = !err;
        return m;
    endfunction

    task automatic frame(input int d, input logic [15:0] b, input logic c, input logic inj);
        inc_vec_t m;
        m = cls(17'(b) + CRC_BYTES, c && !(inj && d == 0));
        if (d == 0) begin
            tx_evt <= '{1'b1, b, c};
            client_tx_inject_crc_fault <= inj;
        end else begin
            rx_evt <= '{1'b1, b, c};
        end
        @(posedge pclk);
        tx_evt.done <= 1'b0;
        rx_evt.done <= 1'b0;
        #1;
        chk("inc_vec", m, d ? rx_inc_vec : tx_inc_vec);
        for (int k = 0; k < NCNT; k++) exp_cnt[d][k] += 64'(m[k]);
        @(posedge pclk);
        @(posedge pclk);
    endtask

    task automatic check_all;
        logic [11:0] a;
        logic [63:0] v;
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < NCNT; k++) begin
                a = (d ? RX_CNT_BASE : TX_CNT_BASE) + 12'(2 * k);
                v = held[d] ? snap[d][k] : exp_cnt[d][k];
                rdc("cnt_lo", a, v[31:0]);
                rdc("cnt_hi", a + 12'h001, v[63:32]);
                rdc("cnt_lo_again", a, v[31:0]);
            end
        end
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        logic [15:0] sizes [15];
        logic [11:0] cfg;
        logic [31:0] d;
        logic        r;
        sizes = '{16'h003b, 16'h003c, 16'h003d, 16'h007b, 16'h007c, 16'h00fb, 16'h00fc,
                  16'h01fb, 16'h01fc, 16'h03fb, 16'h03fc, 16'h05ea, 16'h05eb, 16'h257c,
                  16'h257d};
        pclk = 1'b0;
        presetn = 1'b0;
        apb_req = '0;
        tx_evt = '0;
        rx_evt = '0;
        client_tx_inject_crc_fault = 1'b0;
        exp_cnt = '{default: '0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_all;
        foreach (sizes[i]) frame(0, sizes[i], 1'b0, 1'b0);
        frame(1, 16'h0032, 1'b1, 1'b0);
        frame(1, 16'h003c, 1'b1, 1'b0);
        frame(1, 16'h25e4, 1'b1, 1'b0);
        frame(0, 16'h003c, 1'b1, 1'b1);
        frame(0, 16'h25e4, 1'b1, 1'b0);
        check_all;
        // Snapshot held while live counting goes on, per direction.
        for (int k = 0; k < 2; k++) begin
            cfg = k ? RX_CFG_IDX : TX_CFG_IDX;
            wr(cfg, 32'h00000004);
            rdc("status", cfg + 12'h001, 32'h00000002);
            chk("grant", 1'b1, k ? rx_shadow_granted : tx_shadow_granted);
            snap[k] = exp_cnt[k];
            held[k] = 1'b1;
            frame(k, 16'h003c, 1'b0, 1'b0);
            frame(k, 16'h012c, 1'b1, 1'b0);
            check_all;
            rdc("cfg", cfg, 32'h00000004);
            wr(cfg, 32'h00000000);
            held[k] = 1'b0;
            rdc("status", cfg + 12'h001, 32'h00000000);
            chk("grant", 1'b0, k ? rx_shadow_granted : tx_shadow_granted);
            check_all;
        end
        // Writes to read-only words change nothing; unmapped words answer an error.
        apb(1'b1, TX_CNT_BASE + 12'h006, 32'hffffffff, d, r);
        apb(1'b0, 12'h847, '0, d, r);
        chk("slverr", 1'b1, r);
        wr(TX_CFG_IDX, 32'h00000001);
        exp_cnt[0] = '{default: '0};
        check_all;
        rdc("cfg", TX_CFG_IDX, 32'h00000000);
        wr(RX_CFG_IDX, 32'h00000001);
        exp_cnt[1] = '{default: '0};
        check_all;
        frame(1, 16'h003c, 1'b0, 1'b0);
        frame(0, 16'h003c, 1'b0, 1'b0);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        exp_cnt = '{default: '0};
        check_all;
        test_done;
    end

    // Bounds a hang; the sequence needs well under this many cycles.
    initial begin
        repeat (30000) @(posedge pclk);
        miscompares++;
        test_done;
    end
endmodule
`default_nettype wire
